// ---- verilog/ecr_top.sv ----
// How it works
// - fault register holds latest detected error code
// - internal, comms and serial faults map codes
// - physical faults map to their codes
// - input five to seven at power-up: factory
// - input five to six at power-up: firmware
// - supply register takes the measured voltage at each sample strobe
// - status bit set on supply too high
// - status bit 3 below 15V or above 30V
`timescale 1ns/1ps
module ecr_top
  import ecr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault event strobes from the drive
  input wire ecr_fault_s fault_events,
  // measured supply in millivolts, with its sample strobe
  input wire logic [15:0] supply_mv,
  input wire logic supply_valid,
  // strap pins, only input five is driven by the strap scan
  input wire logic strap_input_five_in,
  input wire logic strap_input_six_in,
  input wire logic strap_input_seven_in,
  output logic strap_input_five_out,
  output logic strap_input_five_oe,
  // boot decision
  output logic boot_factory_restore,
  output logic boot_firmware_mode,
  output logic boot_done,
  // interrupt
  output logic irq
);

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] fault_code_r;
  logic [15:0] fault_code_nxt;
  logic [15:0] supply_r;
  logic volt_bad_r;
  logic volt_high_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_en_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  ecr_boot_e boot_pick;
  logic boot_factory_r;
  logic boot_firmware_r;
  logic boot_done_r;
  logic [1:0] scan_r;
  logic drive_r;

  // ****************************************
  // fault encode
  // ****************************************
  logic fault_any;
  logic [15:0] fault_new;
  ecr_fault_encode u_enc (
    .faults(fault_events),
    .any(fault_any),
    .code(fault_new)
  );

  assign fault_code_nxt = fault_any ? fault_new : fault_code_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      fault_code_r <= ECR_FAULT_RST;
    else
      fault_code_r <= fault_code_nxt;
  end

  // ****************************************
  // supply monitor
  // ****************************************
  wire volt_low_now = supply_mv < ECR_VLOW_MV;
  wire volt_high_now = supply_mv > ECR_VHIGH_MV;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      supply_r <= ECR_SUPPLY_RST;
    else if (supply_valid)
      supply_r <= supply_mv;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      volt_bad_r <= 1'b0;
      volt_high_r <= 1'b0;
    end
    else if (supply_valid)
    begin
      volt_bad_r <= volt_low_now | volt_high_now;
      volt_high_r <= volt_high_now;
    end
  end

  // ****************************************
  // strap scan at reset release
  // ****************************************
  // input five is driven high then low; a pin that follows it is strapped to it.
  // two phases reject a pin merely held high by a pull-up.
  wire scan_busy = !boot_done_r;
  wire follow_seven = strap_input_seven_in == strap_input_five_out;
  wire follow_six = strap_input_six_in == strap_input_five_out;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      scan_r <= 2'h0;
    else if (scan_busy)
      scan_r <= scan_r + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      drive_r <= 1'b0;
    else
      drive_r <= scan_busy & (scan_r != 2'h3);
  end

  logic hit7_r;
  logic hit6_r;

  assign boot_pick = (hit7_r & follow_seven) ? ECR_BOOT_FACTORY :
    (hit6_r & follow_six) ? ECR_BOOT_FIRMWARE : ECR_BOOT_NORMAL;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hit7_r <= 1'b1;
      hit6_r <= 1'b1;
      boot_factory_r <= 1'b0;
      boot_firmware_r <= 1'b0;
      boot_done_r <= 1'b0;
    end
    else if (scan_busy && scan_r != 2'h0)
    begin
      hit7_r <= hit7_r & follow_seven;
      hit6_r <= hit6_r & follow_six;
      if (scan_r == 2'h3)
      begin
        boot_done_r <= 1'b1;
        // outputs come from flops, never from a decode of the choice
        boot_factory_r <= boot_pick == ECR_BOOT_FACTORY;
        boot_firmware_r <= boot_pick == ECR_BOOT_FIRMWARE;
      end
    end
  end

  // phase 1 drives high, phase 2 drives low
  logic five_level_r;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      five_level_r <= 1'b0;
    else
      five_level_r <= scan_busy & (scan_r == 2'h0);
  end

  assign strap_input_five_out = five_level_r;
  assign strap_input_five_oe = drive_r;
  assign boot_factory_restore = boot_factory_r;
  assign boot_firmware_mode = boot_firmware_r;
  assign boot_done = boot_done_r;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel & !penable;
  wire [9:0] idx = paddr[11:2];
  // writes land at the access edge, where the master samples pready
  wire wr_req = setup & pwrite;
  wire wr = psel & penable & pready_r & pwrite;
  wire rd = setup & !pwrite;
  wire hit_fault = idx == ECR_IDX_FAULT;
  wire hit_supply = idx == ECR_IDX_SUPPLY;
  wire hit_status = idx == ECR_IDX_STATUS;
  wire hit_boot = idx == ECR_IDX_BOOT;
  wire hit_istat = idx == ECR_IDX_IRQ_STAT;
  wire hit_ien = idx == ECR_IDX_IRQ_EN;
  wire hit_iclr = idx == ECR_IDX_IRQ_CLR;
  wire mapped = hit_fault | hit_supply | hit_status | hit_boot | hit_istat | hit_ien | hit_iclr;
  wire ro_write = wr_req & (hit_fault | hit_supply | hit_status | hit_boot | hit_istat);
  wire bad = setup & (!mapped | ro_write);
  wire [15:0] status_word = {4'h0, volt_high_r, 7'h00, volt_bad_r, 3'h0};

  logic [31:0] rd_mux;
  always_comb
  begin
    if (hit_fault)
      rd_mux = {16'h0000, fault_code_r};
    else if (hit_supply)
      rd_mux = {16'h0000, supply_r};
    else if (hit_status)
      rd_mux = {16'h0000, status_word};
    else if (hit_boot)
      rd_mux = {29'h0, boot_done_r, boot_firmware_mode, boot_factory_restore};
    else if (hit_istat)
      rd_mux = {30'h0, irq_stat_r};
    else if (hit_ien)
      rd_mux = {30'h0, irq_en_r};
    else
      rd_mux = 32'h0;
  end

  // answer in the access cycle: pready high at the edge after setup
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= bad;
      prdata_r <= (rd & !bad) ? rd_mux : 32'h0;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ****************************************
  // interrupts
  // ****************************************
  // bit 0 new fault, bit 1 supply out of window; set beats clear
  wire [1:0] irq_set = {supply_valid & (volt_low_now | volt_high_now), fault_any};
  wire [1:0] irq_clr = (wr & hit_iclr & pstrb[0]) ? pwdata[1:0] : 2'h0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= ECR_IRQ_RST;
      irq_en_r <= ECR_IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr & hit_ien & pstrb[0])
        irq_en_r <= pwdata[1:0];
      irq_r <= |(irq_stat_nxt & ((wr & hit_ien & pstrb[0]) ? pwdata[1:0] : irq_en_r));
    end
  end

  assign irq = irq_r;

endmodule

// ---- verilog/ecr_pkg.sv ----
package ecr_pkg;

  // ****************************************
  // register map (index, byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] ECR_IDX_FAULT = 10'h19f;
  localparam logic [9:0] ECR_IDX_SUPPLY = 10'h1a0;
  localparam logic [9:0] ECR_IDX_STATUS = 10'h1a1;
  localparam logic [9:0] ECR_IDX_BOOT = 10'h1a2;
  localparam logic [9:0] ECR_IDX_IRQ_STAT = 10'h1a3;
  localparam logic [9:0] ECR_IDX_IRQ_EN = 10'h1a4;
  localparam logic [9:0] ECR_IDX_IRQ_CLR = 10'h1a5;
  localparam logic [9:0] ECR_IDX_THRESH = 10'h1a6;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ECR_STAT_VOLT_BIT = 3;
  localparam int ECR_STAT_HIGH_BIT = 11;
  localparam logic [15:0] ECR_FAULT_RST = 16'h0000;
  localparam logic [15:0] ECR_SUPPLY_RST = 16'h0000;
  // supply in millivolts: 15 V and 30 V limits
  localparam logic [15:0] ECR_VLOW_MV = 16'h3a98;
  localparam logic [15:0] ECR_VHIGH_MV = 16'h7530;
  localparam logic [1:0] ECR_IRQ_RST = 2'h0;

  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [15:0] ECR_C_INT = 16'h0001;
  localparam logic [15:0] ECR_C_TIMING = 16'h0002;
  localparam logic [15:0] ECR_C_APP = 16'h0003;
  localparam logic [15:0] ECR_C_COMM = 16'h1001;
  localparam logic [15:0] ECR_C_BADREG = 16'h1002;
  localparam logic [15:0] ECR_C_PARITY = 16'h1101;
  localparam logic [15:0] ECR_C_FRAMING = 16'h1102;
  localparam logic [15:0] ECR_C_OVERRUN = 16'h1103;
  localparam logic [15:0] ECR_C_CHECKSUM = 16'h1104;
  localparam logic [15:0] ECR_C_ILLFUNC = 16'h1105;
  localparam logic [15:0] ECR_C_ILLDIAG = 16'h1106;
  localparam logic [15:0] ECR_C_OVERCUR = 16'h2001;
  localparam logic [15:0] ECR_C_SUP_LOW = 16'h3001;
  localparam logic [15:0] ECR_C_SUP_HIGH = 16'h3002;
  localparam logic [15:0] ECR_C_TEMP_ELEC = 16'h4001;
  localparam logic [15:0] ECR_C_TEMP_WIND = 16'h4002;
  localparam logic [15:0] ECR_C_TORQUE = 16'h5001;
  localparam logic [15:0] ECR_C_LOCKED = 16'h6001;
  localparam logic [15:0] ECR_C_REGERR = 16'h7001;
  localparam int ECR_NFAULT = 19;

  typedef enum logic [1:0] {ECR_BOOT_NORMAL, ECR_BOOT_FACTORY, ECR_BOOT_FIRMWARE} ecr_boot_e;

  // fault event strobes, one bit per code, bit 0 highest priority
  typedef struct packed {
    logic [ECR_NFAULT-1:0] hit;
  } ecr_fault_s;

endpackage

// ---- verilog/ecr_fault_encode.sv ----
`timescale 1ns/1ps
module ecr_fault_encode
  import ecr_pkg::*;
(
  // fault strobes
  input wire ecr_fault_s faults,
  // encoded result
  output logic any,
  output logic [15:0] code
);

  // ****************************************
  // code table
  // ****************************************
  function automatic logic [15:0] ecr_code(input int i);
    logic [15:0] c;
    c = ECR_C_INT;
    case (i)
      1: c = ECR_C_TIMING;
      2: c = ECR_C_APP;
      3: c = ECR_C_COMM;
      4: c = ECR_C_BADREG;
      5: c = ECR_C_PARITY;
      6: c = ECR_C_FRAMING;
      7: c = ECR_C_OVERRUN;
      8: c = ECR_C_CHECKSUM;
      9: c = ECR_C_ILLFUNC;
      10: c = ECR_C_ILLDIAG;
      11: c = ECR_C_OVERCUR;
      12: c = ECR_C_SUP_LOW;
      13: c = ECR_C_SUP_HIGH;
      14: c = ECR_C_TEMP_ELEC;
      15: c = ECR_C_TEMP_WIND;
      16: c = ECR_C_TORQUE;
      17: c = ECR_C_LOCKED;
      18: c = ECR_C_REGERR;
      default: c = ECR_C_INT;
    endcase
    return c;
  endfunction

  assign any = |faults.hit;

  // lowest index wins when several faults strike in one cycle
  always_comb
  begin
    code = 16'h0000;
    for (int i = ECR_NFAULT - 1; i >= 0; i--)
    begin
      if (faults.hit[i])
      begin
        code = ecr_code(i);
      end
    end
  end

endmodule

// ---- tb/ecr_properties.sv ----
`timescale 1ns/1ps
// ********
// bus and boot checks
// ********
module ecr_chk
  import ecr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // strap and boot
  input wire logic strap_input_five_out,
  input wire logic strap_input_five_oe,
  input wire logic boot_factory_restore,
  input wire logic boot_firmware_mode,
  input wire logic boot_done
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_set;
    psel && !penable;
  endsequence
  sequence s_hi;
    strap_input_five_oe && strap_input_five_out;
  endsequence
  sequence s_lo;
    strap_input_five_oe && !strap_input_five_out;
  endsequence
  AST_READY: assert property (s_set |=> pready)
    else $error("no ready after setup");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RD_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_FAULT_RO: assert property (
    (s_set and (pwrite && paddr == {ECR_IDX_FAULT, 2'b00})) |=> pslverr)
    else $error("fault register written");
  AST_UNMAPPED: assert property ((s_set and paddr == {ECR_IDX_THRESH, 2'b00})
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_STRAP_SCAN: assert property (
    $rose(rst_n) |-> ##[0:3] s_hi ##[1:3] s_lo)
    else $error("strap scan missing");
  AST_BOOT_TIME: assert property ($rose(rst_n) |-> ##[0:8] boot_done)
    else $error("boot decision late");
  AST_BOOT_ONE: assert property (
    boot_done |-> !(boot_factory_restore && boot_firmware_mode))
    else $error("both boot modes");
  AST_BOOT_HOLD: assert property (boot_done |=> boot_done
    && $stable(boot_factory_restore) && $stable(boot_firmware_mode))
    else $error("boot decision moved");
endmodule

// ---- tb/ecr_host.sv ----
`timescale 1ns/1ps
// ********
// apb host
// ********
module ecr_host (
  // clock and answer
  input wire logic ref_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  logic hung;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    hung = 1'b0;
  end
  // request held until pready is sampled high or 50 edges pass
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (!pready && n < 50);
    hung = !pready;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ********
// bench
// ********
module tb_top
  import ecr_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, re, hi, pin_five;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic supply_valid = 1'b0;
  logic [15:0] supply_mv = 16'h0;
  logic [15:0] v;
  ecr_fault_s fault_events = '0;
  logic strap_input_five_in, strap_input_six_in, strap_input_seven_in;
  logic strap_input_five_out, strap_input_five_oe, irq;
  logic boot_factory_restore, boot_firmware_mode, boot_done;
  logic [1:0] mode = 2'h0;
  logic [18:0] mv;
  logic [31:0] seed = 32'h77159305;
  int err_count = 0;
  int compares = 0;
  int k;
  logic [15:0] codes[$] = '{ECR_C_INT, ECR_C_TIMING, ECR_C_APP, ECR_C_COMM,
    ECR_C_BADREG, ECR_C_PARITY, ECR_C_FRAMING, ECR_C_OVERRUN, ECR_C_CHECKSUM,
    ECR_C_ILLFUNC, ECR_C_ILLDIAG, ECR_C_OVERCUR, ECR_C_SUP_LOW, ECR_C_SUP_HIGH,
    ECR_C_TEMP_ELEC, ECR_C_TEMP_WIND, ECR_C_TORQUE, ECR_C_LOCKED, ECR_C_REGERR};
  logic [15:0] vq[$] = '{ECR_VLOW_MV - 16'h1, ECR_VLOW_MV, ECR_VHIGH_MV,
    ECR_VHIGH_MV + 16'h1, 16'h0, 16'h4e20};
  always #10 ref_clk = ~ref_clk;
  // pins idle high through pull-ups
  assign pin_five = strap_input_five_oe ? strap_input_five_out : 1'b1;
  assign strap_input_five_in = pin_five;
  assign strap_input_six_in = (mode == 2'h2) ? pin_five : 1'b1;
  assign strap_input_seven_in = (mode == 2'h1) ? pin_five : 1'b1;
  ecr_top dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .fault_events, .supply_mv, .supply_valid,
    .strap_input_five_in, .strap_input_six_in, .strap_input_seven_in,
    .strap_input_five_out, .strap_input_five_oe, .boot_factory_restore,
    .boot_firmware_mode, .boot_done, .irq);
  ecr_host h (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb);
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop();
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [9:0] i, input logic [31:0] d);
    h.xfer(w, {i, 2'b00}, d, rv, re);
    if (h.hung)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  task rdc(input logic [9:0] i, input logic [31:0] e);
    acc(1'b0, i, 32'h0);
    chk({31'h0, re}, 32'h0);
    chk(rv, e);
  endtask
  task pulse(input logic [18:0] m);
    fault_events <= ecr_fault_s'(m);
    @(posedge ref_clk);
    fault_events <= '0;
  endtask
  task sup(input logic [15:0] s);
    supply_mv <= s;
    supply_valid <= 1'b1;
    @(posedge ref_clk);
    supply_valid <= 1'b0;
  endtask
  task irqc(input logic e);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  initial
  begin
    // straps: firmware, factory, then plain
    for (int m = 2; m >= 0; m--)
    begin
      mode <= m[1:0];
      rst_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      k = 0;
      while (boot_done !== 1'b1 && k < 20)
      begin
        @(negedge ref_clk);
        k++;
      end
      chk({31'h0, k < 20}, 32'h1);
      if (k >= 20)
        report_and_stop();
      rdc(ECR_IDX_BOOT, 32'h4 + m);
      rdc(ECR_IDX_FAULT, {16'h0, ECR_FAULT_RST});
      rdc(ECR_IDX_IRQ_EN, {30'h0, ECR_IRQ_RST});
    end
    // lowest index wins on a tie
    for (int i = 0; i < 30; i++)
    begin
      seed = lf(seed);
      mv = (i < 19) ? 19'h1 << i : seed[18:0] | 19'h40000;
      k = 0;
      while (!mv[k])
        k++;
      pulse(mv);
      rdc(ECR_IDX_FAULT, {16'h0, codes[k]});
      rdc(ECR_IDX_FAULT, {16'h0, codes[k]});
    end
    acc(1'b1, ECR_IDX_FAULT, 32'h5a5a);
    chk({31'h0, re}, 32'h1);
    rdc(ECR_IDX_FAULT, {16'h0, codes[k]});
    acc(1'b0, ECR_IDX_THRESH, 32'h0);
    chk({31'h0, re}, 32'h1);
    // supply window edges
    foreach (vq[j])
    begin
      seed = lf(seed);
      v = (j == 4) ? seed[15:0] : vq[j];
      sup(v);
      rdc(ECR_IDX_SUPPLY, {16'h0, v});
      hi = v > ECR_VHIGH_MV;
      rdc(ECR_IDX_STATUS, {20'h0, hi, 7'h0, hi | (v < ECR_VLOW_MV), 3'h0});
    end
    acc(1'b1, ECR_IDX_IRQ_CLR, 32'h3);
    rdc(ECR_IDX_IRQ_STAT, 32'h0);
    acc(1'b1, ECR_IDX_IRQ_EN, 32'h1);
    pulse(19'h20);
    rdc(ECR_IDX_IRQ_STAT, 32'h1);
    irqc(1'b1);
    sup(16'h9c40);
    rdc(ECR_IDX_IRQ_STAT, 32'h3);
    acc(1'b1, ECR_IDX_IRQ_CLR, 32'h1);
    rdc(ECR_IDX_IRQ_STAT, 32'h2);
    irqc(1'b0);
    acc(1'b1, ECR_IDX_IRQ_EN, 32'h3);
    irqc(1'b1);
    acc(1'b1, ECR_IDX_IRQ_CLR, 32'h2);
    rdc(ECR_IDX_IRQ_STAT, 32'h0);
    irqc(1'b0);
    report_and_stop();
  end
endmodule
bind ecr_top ecr_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .strap_input_five_out, .strap_input_five_oe,
  .boot_factory_restore, .boot_firmware_mode, .boot_done);
